//--- core/slpc_pkg.sv
package slpc_pkg;

    // ------------------------------------------------------------
    // Register byte offsets on the bus.
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_DESC_LO = 8'h04;
    localparam logic [7:0] REG_DESC_HI = 8'h08;
    localparam logic [7:0] REG_CODE_HI = 8'h0C;
    localparam logic [7:0] REG_SEL     = 8'h10;
    localparam logic [7:0] REG_PAGE    = 8'h14;
    localparam logic [7:0] REG_GDT_LIM = 8'h18;
    localparam logic [7:0] REG_IDT_LIM = 8'h1C;
    localparam logic [7:0] REG_LDT_LIM = 8'h20;
    localparam logic [7:0] REG_TSS_LIM = 8'h24;
    localparam logic [7:0] REG_STATUS  = 8'h28;
    localparam logic [7:0] REG_FAULTS  = 8'h2C;

    // ------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------
    localparam int CTRL_PE    = 0;
    localparam int CTRL_PG    = 1;
    localparam int CTRL_LMA   = 2;
    localparam int CTRL_WP    = 3;
    localparam int CTRL_W     = 4;
    localparam int DH_TYPE_LO = 8;
    localparam int DH_TYPE_HI = 11;
    localparam int DH_E       = 10;
    localparam int DH_S       = 12;
    localparam int DH_DPL_LO  = 13;
    localparam int DH_DPL_HI  = 14;
    localparam int DH_LIM_LO  = 16;
    localparam int DH_LIM_HI  = 19;
    localparam int DH_L       = 21;
    localparam int DH_DB      = 22;
    localparam int DH_G       = 23;
    localparam int DL_LIM_HI  = 15;
    localparam int SEL_RPL_HI = 1;
    localparam int SEL_TI     = 2;
    localparam int SEL_IDX_LO = 3;
    localparam int SEL_CS_LO  = 16;
    localparam int PTE_RW     = 1;
    localparam int PTE_US     = 2;

    // ------------------------------------------------------------
    // Reset values and fixed figures.
    // ------------------------------------------------------------
    localparam logic [31:0] RST_WORD    = 32'h0000_0000;
    localparam logic [15:0] RST_TBL_LIM = 16'hFFFF;
    localparam logic [31:0] UPPER_BIG   = 32'hFFFF_FFFF;
    localparam logic [31:0] UPPER_SMALL = 32'h0000_FFFF;
    localparam logic [11:0] GRAN_FILL   = 12'hFFF;
    localparam logic [2:0]  ENTRY_FILL  = 3'h7;
    localparam logic [1:0]  PRIV_USER   = 2'h3;

    // Kinds of check request.
    typedef enum logic [1:0]
    {
        KIND_SEG = 2'h0,
        KIND_SEL = 2'h1,
        KIND_IDT = 2'h2,
        KIND_TSS = 2'h3
    } slpc_kind_t;

    // Operating modes as shown in status.
    typedef enum logic [1:0]
    {
        MODE_REAL   = 2'h0,
        MODE_PROT   = 2'h1,
        MODE_COMPAT = 2'h3,
        MODE_LONG   = 2'h2
    } slpc_mode_t;

    // Bytes beyond the first touched by an access of a given size.
    function automatic logic [32:0] sizeAdj(input logic [1:0] size);
        logic [32:0] adj;
        adj = {30'h0, 3'h7} >> (2'h3 - size);
        return adj;
    endfunction

    // Byte-lane merge of a bus write into a register.
    function automatic logic [31:0] laneMerge(
        input logic [31:0] old,
        input logic [31:0] dat,
        input logic [3:0]  sel
    );
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                res[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
        return res;
    endfunction

endpackage

//--- core/slpc_limit_check.sv
`timescale 1ns/100ps
module slpc_limit_check
    import slpc_pkg::*;
(
    input  wire logic [31:0] descLo,
    input  wire logic [31:0] descHi,
    input  wire logic [31:0] offset,
    input  wire logic [1:0]  size,
    output logic             limitOver
);

    logic [19:0] rawLimit;
    logic [31:0] effLimit;
    logic [32:0] lastByte;
    logic [31:0] upper;
    logic        expDown;

    // ------------------------------------------------------------
    // Effective limit from the raw field and granularity.
    // ------------------------------------------------------------
    // Raw limit joins the low and high limit fields.
    assign rawLimit = {descHi[DH_LIM_HI:DH_LIM_LO], descLo[DL_LIM_HI:0]};
    // Page granularity leaves the low twelve offset bits unchecked.
    assign effLimit = descHi[DH_G] ? {rawLimit, GRAN_FILL}
                                   : {12'h000, rawLimit};
    // Expand-down only applies to data descriptors.
    assign expDown  = descHi[DH_S] && !descHi[DH_TYPE_HI] && descHi[DH_E];
    assign upper    = descHi[DH_DB] ? UPPER_BIG : UPPER_SMALL;
    // Last byte touched, kept one bit wider to avoid wrap.
    assign lastByte = {1'b0, offset} + sizeAdj(size);

    // ------------------------------------------------------------
    // Range test for normal and expand-down segments.
    // ------------------------------------------------------------
    // The offset range test for both segment directions.
    always_comb
    begin
        if (expDown)
        begin
            limitOver = (offset <= effLimit) || (lastByte > {1'b0, upper});
        end
        else
        begin
            limitOver = lastByte > {1'b0, effLimit};
        end
    end

endmodule

//--- core/slpc_checker.sv
// The implementer's own choices: the register offsets and register access over Wishbone.
`timescale 1ns/100ps
// Functional notes
// - Check finishes before access; fault blocks access.
// - Protection enable bit turns segment checking on.
// - Privilege zero everywhere still gets limit checks.
// - Paging enable bit turns page checks on when protection is enabled.
// - Upper bit 12 is descriptor class.
// - Upper bits 8 to 11 are type.
// - Raw limit from two split fields.
// - Upper bit 23 is granularity.
// - Upper bit 10 is data expand-down.
// - Upper bits 13 and 14 are privilege.
// - Selector low bits give requested, code current.
// - Page entry bit 2 user, bit 1 write.
// - Long mode treats code base as zero.
// - Long mode active plus L picks 64-bit.
// - Compatibility mode size follows default-size flag.
// - L with D clear is 32/64; both faults.
// - Byte granularity limit is raw field.
// - Page granularity leaves twelve offset bits unchecked.
// - Normal segments fault past size-adjusted limit.
// - Expand-down valid range above limit to bound.
// - Global and interrupt table limits bound selection.
// - Local table and task segment limits bound access.
module slpc_checker
(
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    input  wire logic                   wbCyc,
    input  wire logic                   wbStb,
    input  wire logic                   wbWe,
    input  wire logic [7:0]             wbAdr,
    input  wire logic [3:0]             wbSel,
    input  wire logic [31:0]            wbDatI,
    output logic [31:0]                 wbDatO,
    output logic                        wbAck,
    input  wire logic                   reqValid,
    input  wire slpc_pkg::slpc_kind_t   reqKind,
    input  wire logic [31:0]            reqOffset,
    input  wire logic [1:0]             reqSize,
    input  wire logic                   reqWrite,
    output logic                        rspValid,
    output logic                        rspFault,
    output logic                        rspProceed,
    output logic [31:0]                 rspLinear
);
    import slpc_pkg::*;

    // ------------------------------------------------------------
    // Declarations.
    // ------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl;
    logic [31:0]       descLo, descHi, codeHi, selWord, pageEntry;
    logic [15:0]       gdtLimit, idtLimit;
    logic [31:0]       ldtLimit, tssLimit, faultCount;
    logic              lastFault, lastLimit, lastCode, lastTable, lastPage;
    logic              wbReq, wbWrite;
    logic [31:0]       rdData, segBase, next_linear;
    logic              limOver, protOn, pageOn, longMode, codeBad, defSize32;
    slpc_mode_t        mode;
    logic [1:0]        curPriv, reqPriv, descPriv, addrCode;
    logic              sysClass;
    logic [3:0]        segType;
    logic              pageUser, pageWrite, pageDeny;
    logic              next_limFault, next_tblFault, next_pageFault, next_fault;

    // Entry index plus its last byte must lie inside the table.
    function automatic logic entryOver(
        input logic [12:0] index,
        input logic [31:0] limit
    );
        return {16'h0000, index, ENTRY_FILL} > limit;
    endfunction

    // ------------------------------------------------------------
    // Bus handshake.
    // ------------------------------------------------------------
    // A request is served once; ack drops the cycle after it rose.
    assign wbReq   = wbCyc && wbStb && !wbAck;
    assign wbWrite = wbCyc && wbStb && wbAck && wbWe;  // Lands at the edge that shows ack.

    // Ack follows each new request by one cycle.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wbAck <= 1'b0;
        end
        else
        begin
            wbAck <= wbReq;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers.
    // ------------------------------------------------------------
    // Software loads mode bits, descriptors and table limits.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl      <= RST_WORD[CTRL_W-1:0];
            descLo    <= RST_WORD;
            descHi    <= RST_WORD;
            codeHi    <= RST_WORD;
            selWord   <= RST_WORD;
            pageEntry <= RST_WORD;
            gdtLimit  <= RST_TBL_LIM;
            idtLimit  <= RST_TBL_LIM;
            ldtLimit  <= RST_WORD;
            tssLimit  <= RST_WORD;
        end
        else if (wbWrite)
        begin
            unique case (wbAdr)
                REG_CTRL:    ctrl      <= CTRL_W'(laneMerge({28'h0, ctrl}, wbDatI, wbSel));
                REG_DESC_LO: descLo    <= laneMerge(descLo, wbDatI, wbSel);
                REG_DESC_HI: descHi    <= laneMerge(descHi, wbDatI, wbSel);
                REG_CODE_HI: codeHi    <= laneMerge(codeHi, wbDatI, wbSel);
                REG_SEL:     selWord   <= laneMerge(selWord, wbDatI, wbSel);
                REG_PAGE:    pageEntry <= laneMerge(pageEntry, wbDatI, wbSel);
                REG_GDT_LIM: gdtLimit  <= 16'(laneMerge({16'h0, gdtLimit}, wbDatI, wbSel));
                REG_IDT_LIM: idtLimit  <= 16'(laneMerge({16'h0, idtLimit}, wbDatI, wbSel));
                REG_LDT_LIM: ldtLimit  <= laneMerge(ldtLimit, wbDatI, wbSel);
                REG_TSS_LIM: tssLimit  <= laneMerge(tssLimit, wbDatI, wbSel);
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Field decode and operating mode.
    // ------------------------------------------------------------
    // Protection follows the enable bits alone; nothing else gates it.
    assign protOn   = ctrl[CTRL_PE];
    assign pageOn   = ctrl[CTRL_PE] && ctrl[CTRL_PG];
    assign longMode = ctrl[CTRL_LMA] && codeHi[DH_L];
    assign sysClass = descHi[DH_S];
    assign segType  = descHi[DH_TYPE_HI:DH_TYPE_LO];
    assign descPriv = descHi[DH_DPL_HI:DH_DPL_LO];
    assign reqPriv  = selWord[SEL_RPL_HI:0];
    assign curPriv  = selWord[SEL_CS_LO+SEL_RPL_HI:SEL_CS_LO];
    assign pageUser  = pageEntry[PTE_US];
    assign pageWrite = pageEntry[PTE_RW];

    // The reserved flag pair on a long code segment is refused.
    assign codeBad = ctrl[CTRL_LMA] && codeHi[DH_L] && codeHi[DH_DB];

    // Mode and default sizes from the code descriptor flags.
    always_comb
    begin
        if (!protOn)
        begin
            mode      = MODE_REAL;
            defSize32 = 1'b0;
            addrCode  = 2'h0;
        end
        else if (!ctrl[CTRL_LMA])
        begin
            mode      = MODE_PROT;
            defSize32 = codeHi[DH_DB];
            addrCode  = {1'b0, codeHi[DH_DB]};
        end
        else if (longMode)
        begin
            mode      = MODE_LONG;
            defSize32 = 1'b1;
            addrCode  = 2'h2;
        end
        else
        begin
            mode      = MODE_COMPAT;
            defSize32 = codeHi[DH_DB];
            addrCode  = {1'b0, codeHi[DH_DB]};
        end
    end

    // ------------------------------------------------------------
    // Segment limit and page checks.
    // ------------------------------------------------------------
    slpc_limit_check u_limit
    (
        .descLo    (descLo),
        .descHi    (descHi),
        .offset    (reqOffset),
        .size      (reqSize),
        .limitOver (limOver)
    );

    // User code needs a user page, and write rights to write; supervisor
    // writes to read-only pages fault only under write protect.
    always_comb
    begin
        if (!pageOn)
        begin
            pageDeny = 1'b0;
        end
        else if (curPriv == PRIV_USER)
        begin
            pageDeny = !pageUser || (reqWrite && !pageWrite);
        end
        else
        begin
            pageDeny = reqWrite && !pageWrite && ctrl[CTRL_WP];
        end
    end

    // Base is taken as zero in long mode, else from the descriptor.
    assign segBase = {descHi[31:24], descHi[7:0], descLo[31:16]};
    assign next_linear = longMode ? reqOffset : segBase + reqOffset;

    // ------------------------------------------------------------
    // Fault decision per request kind.
    // ------------------------------------------------------------
    // Privilege levels are not compared here, so level zero
    // everywhere still meets every limit check below.
    always_comb
    begin
        next_limFault  = 1'b0;
        next_tblFault  = 1'b0;
        next_pageFault = 1'b0;
        unique case (reqKind)
            KIND_SEG:
            begin
                // Long mode runs no segment limit check.
                next_limFault  = protOn && !longMode && limOver;
                next_pageFault = pageDeny;
            end
            KIND_SEL:
            begin
                // The table indicator picks the local or the global table.
                next_tblFault = protOn && entryOver(selWord[15:SEL_IDX_LO],
                    selWord[SEL_TI] ? ldtLimit : {16'h0, gdtLimit});
            end
            KIND_IDT:
            begin
                next_tblFault = protOn &&
                    entryOver({5'h00, reqOffset[7:0]}, {16'h0, idtLimit});
            end
            KIND_TSS:
            begin
                next_tblFault = protOn &&
                    ({1'b0, reqOffset} + sizeAdj(reqSize) > {1'b0, tssLimit});
            end
        endcase
    end

    // Any failed check replaces the access with a fault.
    assign next_fault = (protOn && codeBad) || next_limFault ||
                        next_tblFault || next_pageFault;

    // ------------------------------------------------------------
    // Answer to the pipeline.
    // ------------------------------------------------------------
    // The verdict comes one cycle after the request, before the
    // pipeline may start the memory cycle.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            rspValid   <= 1'b0;
            rspFault   <= 1'b0;
            rspProceed <= 1'b0;
            rspLinear  <= RST_WORD;
        end
        else
        begin
            rspValid   <= reqValid;
            rspFault   <= reqValid && next_fault;
            rspProceed <= reqValid && !next_fault;
            if (reqValid)
            begin
                rspLinear <= next_linear;
            end
        end
    end

    // Causes of the most recent verdict, kept until the next one.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            lastFault <= 1'b0;
            lastLimit <= 1'b0;
            lastCode  <= 1'b0;
            lastTable <= 1'b0;
            lastPage  <= 1'b0;
        end
        else if (reqValid)
        begin
            lastFault <= next_fault;
            lastLimit <= next_limFault;
            lastCode  <= protOn && codeBad;
            lastTable <= next_tblFault;
            lastPage  <= next_pageFault;
        end
    end

    // Fault counter; a fault in the clearing cycle still counts.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            faultCount <= RST_WORD;
        end
        else if (wbWrite && wbAdr == REG_FAULTS)
        begin
            faultCount <= {31'h0, reqValid && next_fault};
        end
        else if (reqValid && next_fault)
        begin
            faultCount <= faultCount + 32'h1;
        end
    end

    // ------------------------------------------------------------
    // Read path.
    // ------------------------------------------------------------
    // Unmapped addresses read as zero.
    always_comb
    begin
        unique case (wbAdr)
            REG_CTRL:    rdData = {28'h0, ctrl};
            REG_DESC_LO: rdData = descLo;
            REG_DESC_HI: rdData = descHi;
            REG_CODE_HI: rdData = codeHi;
            REG_SEL:     rdData = selWord;
            REG_PAGE:    rdData = pageEntry;
            REG_GDT_LIM: rdData = {16'h0, gdtLimit};
            REG_IDT_LIM: rdData = {16'h0, idtLimit};
            REG_LDT_LIM: rdData = ldtLimit;
            REG_TSS_LIM: rdData = tssLimit;
            REG_STATUS:
            begin
                rdData = {11'h0, addrCode, defSize32, segType, sysClass,
                          descPriv, reqPriv, curPriv, mode,
                          lastPage, lastTable, lastCode, lastLimit, lastFault};
            end
            REG_FAULTS:  rdData = faultCount;
            default:     rdData = RST_WORD;
        endcase
    end

    // Read data is captured with the ack.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wbDatO <= RST_WORD;
        end
        else if (wbReq)
        begin
            wbDatO <= wbWe ? RST_WORD : rdData;
        end
    end

endmodule

//--- bench/slpc_checker_sva.sv
`timescale 1ns/100ps
module slpc_checker_sva
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        wbCyc,
    input wire logic        wbStb,
    input wire logic        wbWe,
    input wire logic [7:0]  wbAdr,
    input wire logic [3:0]  wbSel,
    input wire logic [31:0] wbDatI,
    input wire logic [31:0] wbDatO,
    input wire logic        wbAck,
    input wire logic        reqValid,
    input wire logic        rspValid,
    input wire logic        rspFault,
    input wire logic        rspProceed
);
    import slpc_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic pe;
    // Shadow of the protect enable bit, taken from accepted bus writes.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            pe <= 1'h0;
        else if (wbCyc && wbStb && wbAck && wbWe && wbAdr == REG_CTRL && wbSel[0])
            pe <= wbDatI[CTRL_PE];
    end
    // A served bus request gives exactly one ack pulse.
    sequence busReq; wbCyc && wbStb && !wbAck; endsequence
    sequence ackOnce; wbAck ##1 !wbAck; endsequence
    ack_once_a: assert property (busReq |=> ackOnce) else $error("ack not one pulse");
    ack_cause_a: assert property (wbAck |-> $past(wbCyc && wbStb)) else $error("stray ack");
    wr_zero_a: assert property (wbAck && $past(wbWe) |-> wbDatO == 32'h0)
        else $error("write returned data");
    unmap_zero_a: assert property (wbAck && $past(!wbWe && wbAdr > REG_FAULTS) |-> wbDatO == 32'h0)
        else $error("unmapped read not zero");
    rsp_next_a: assert property (reqValid |=> rspValid && (rspFault ^ rspProceed))
        else $error("check answer missing");
    rsp_cause_a: assert property (rspValid |-> $past(reqValid))
        else $error("answer without request");
    rsp_quiet_a: assert property (!rspValid |-> !(rspFault || rspProceed))
        else $error("outcome outside answer");
    real_ok_a: assert property (reqValid && !pe |=> rspProceed)
        else $error("fault with protection off");
endmodule
bind slpc_checker slpc_checker_sva chk (
    .sys_clk(sys_clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck),
    .reqValid(reqValid), .rspValid(rspValid), .rspFault(rspFault), .rspProceed(rspProceed));

//--- bench/slpc_pipe_model.sv
`timescale 1ns/100ps
module slpc_pipe_model
(
    input wire logic             sys_clk,
    output slpc_pkg::slpc_kind_t reqKind,
    output logic                 reqValid,
    output logic [31:0]          reqOffset,
    output logic [1:0]           reqSize,
    output logic                 reqWrite,
    input wire logic             rspValid,
    input wire logic             rspFault,
    input wire logic             rspProceed,
    input wire logic [31:0]      rspLinear
);
    import slpc_pkg::*;
    // The pipeline starts idle.
    initial
    begin
        reqValid = 1'h0;
        reqKind = KIND_SEG;
        reqOffset = 32'h0;
        reqSize = 2'h0;
        reqWrite = 1'h0;
    end
    // One request pulse; the offset is scrambled once released.
    task automatic issue(input slpc_kind_t k, input logic [31:0] off, input logic [1:0] sz,
                         input logic wr, output logic [1:0] res, output logic [31:0] lin);
        res = 2'h0;
        lin = 32'h0;
        @(posedge sys_clk);
        reqValid <= 1'h1;
        reqKind <= k;
        reqOffset <= off;
        reqSize <= sz;
        reqWrite <= wr;
        @(posedge sys_clk);
        reqValid <= 1'h0;
        reqOffset <= ~off;
        for (int n = 0; n < 4 && res == 2'h0; n++)
        begin
            @(posedge sys_clk);
            if (rspValid === 1'h1)
            begin
                res = {rspFault, rspProceed};
                lin = rspLinear;
            end
        end
    endtask
endmodule

//--- bench/tb.sv
`timescale 1ns/100ps
module tb;
    import slpc_pkg::*;
    logic        sys_clk = 1'h0, rst = 1'h1, wbCyc = 1'h0, wbStb = 1'h0, wbWe = 1'h0;
    logic [7:0]  wbAdr = 8'h0;
    logic [3:0]  wbSel = 4'h0;
    logic [31:0] wbDatI = 32'h0, wbDatO, rspLinear, rd, lin, reqOffset;
    logic        wbAck, reqValid, reqWrite, rspValid, rspFault, rspProceed;
    logic [1:0]  reqSize, res;
    slpc_kind_t  reqKind;
    int          err_total = 0, compares = 0, cycles = 0;
    slpc_checker dut (.sys_clk(sys_clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
        .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck),
        .reqValid(reqValid), .reqKind(reqKind), .reqOffset(reqOffset), .reqSize(reqSize),
        .reqWrite(reqWrite), .rspValid(rspValid), .rspFault(rspFault),
        .rspProceed(rspProceed), .rspLinear(rspLinear));
    slpc_pipe_model pipe (.sys_clk(sys_clk), .reqKind(reqKind), .reqValid(reqValid),
        .reqOffset(reqOffset), .reqSize(reqSize), .reqWrite(reqWrite), .rspValid(rspValid),
        .rspFault(rspFault), .rspProceed(rspProceed), .rspLinear(rspLinear));
    // Clock and a cycle ceiling that ends a hung run.
    initial
    begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_total++;
            close_out;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("mismatches=%0d compares=%0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // One classic bus cycle, held until ack is seen.
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        wbCyc <= 1'h1;
        wbStb <= 1'h1;
        wbWe <= we;
        wbAdr <= a;
        wbDatI <= d;
        wbSel <= 4'hF;
        do @(posedge sys_clk); while (wbAck !== 1'h1);
        rd = wbDatO;
        wbCyc <= 1'h0;
        wbStb <= 1'h0;
    endtask
    // Check request; wf holds the write bit and the expected fault.
    task automatic ex(input slpc_kind_t k, input logic [31:0] o, input logic [1:0] s,
                      input logic [1:0] wf);
        pipe.issue(k, o, s, wf[1], res, lin);
        chk({30'h0, res}, {30'h0, wf[0], !wf[0]});
    endtask
    task automatic t_limit;
        bus(0, REG_GDT_LIM, 32'h0);
        chk(rd, 32'hFFFF);
        bus(0, 8'h40, 32'h0);
        bus(1, REG_DESC_LO, 32'h100);
        bus(1, REG_DESC_HI, 32'h1200);
        ex(KIND_SEG, 32'h10000, 2'h0, 2'h0);
        bus(1, REG_CTRL, 32'h1);
        for (int s = 0; s < 4; s++)
        begin
            ex(KIND_SEG, 32'h101 - (32'h1 << s), s[1:0], 2'h0);
            ex(KIND_SEG, 32'h102 - (32'h1 << s), s[1:0], 2'h3);
        end
        bus(1, REG_DESC_HI, 32'h11200);
        ex(KIND_SEG, 32'h10100, 2'h0, 2'h0);
        ex(KIND_SEG, 32'h10101, 2'h0, 2'h1);
        bus(1, REG_DESC_HI, 32'h801200);
        ex(KIND_SEG, 32'h100FFF, 2'h0, 2'h0);
        ex(KIND_SEG, 32'h101000, 2'h0, 2'h1);
    endtask
    task automatic t_expand;
        bus(1, REG_DESC_LO, 32'hFF);
        bus(1, REG_DESC_HI, 32'h1600);
        ex(KIND_SEG, 32'hFF, 2'h0, 2'h1);
        ex(KIND_SEG, 32'h100, 2'h0, 2'h0);
        ex(KIND_SEG, 32'hFFFE, 2'h1, 2'h0);
        ex(KIND_SEG, 32'hFFFF, 2'h1, 2'h1);
        bus(1, REG_DESC_HI, 32'h401600);
        ex(KIND_SEG, 32'h10000, 2'h0, 2'h0);
        ex(KIND_SEG, 32'hFFFFFFFD, 2'h2, 2'h1);
    endtask
    task automatic t_long;
        bus(1, REG_CTRL, 32'h5);
        bus(1, REG_DESC_LO, 32'h12340000);
        bus(1, REG_DESC_HI, 32'h1200);
        bus(1, REG_CODE_HI, 32'h600000);
        ex(KIND_SEG, 32'h0, 2'h0, 2'h1);
        bus(1, REG_CODE_HI, 32'h200000);
        ex(KIND_SEG, 32'h5000, 2'h3, 2'h0);
        chk(lin, 32'h5000);
        bus(0, REG_STATUS, 32'h0);
        chk({27'h0, rd[20:18], rd[6:5]}, {27'h0, 3'h5, MODE_LONG});
        bus(1, REG_CODE_HI, 32'h0);
        ex(KIND_SEG, 32'h5000, 2'h0, 2'h1);
        bus(0, REG_STATUS, 32'h0);
        chk({27'h0, rd[20:18], rd[6:5]}, {27'h0, 3'h0, MODE_COMPAT});
        bus(1, REG_CODE_HI, 32'h400000);
        ex(KIND_SEG, 32'h0, 2'h0, 2'h0);
        chk(lin, 32'h1234);
        bus(0, REG_STATUS, 32'h0);
        chk({29'h0, rd[20:18]}, {29'h0, 3'h3});
    endtask
    task automatic t_table;
        bus(1, REG_CTRL, 32'h1);
        bus(1, REG_GDT_LIM, 32'hF);
        bus(1, REG_LDT_LIM, 32'hF);
        bus(1, REG_IDT_LIM, 32'hF);
        bus(1, REG_TSS_LIM, 32'h67);
        bus(1, REG_FAULTS, 32'h0);
        bus(1, REG_SEL, 32'h8);
        ex(KIND_SEL, 32'h0, 2'h0, 2'h0);
        bus(1, REG_SEL, 32'h10);
        ex(KIND_SEL, 32'h0, 2'h0, 2'h1);
        bus(1, REG_SEL, 32'hC);
        ex(KIND_SEL, 32'h0, 2'h0, 2'h0);
        bus(1, REG_LDT_LIM, 32'hE);
        ex(KIND_SEL, 32'h0, 2'h0, 2'h1);
        ex(KIND_IDT, 32'h1, 2'h0, 2'h0);
        ex(KIND_IDT, 32'h2, 2'h0, 2'h1);
        ex(KIND_TSS, 32'h64, 2'h2, 2'h0);
        ex(KIND_TSS, 32'h65, 2'h2, 2'h1);
        bus(0, REG_FAULTS, 32'h0);
        chk(rd, 32'h4);
    endtask
    task automatic t_page;
        bus(1, REG_CTRL, 32'h3);
        bus(1, REG_DESC_LO, 32'h0);
        bus(1, REG_DESC_HI, 32'h8F7A00);
        bus(1, REG_SEL, 32'h30000);
        bus(1, REG_PAGE, 32'h0);
        ex(KIND_SEG, 32'h10, 2'h0, 2'h1);
        bus(1, REG_PAGE, 32'h4);
        ex(KIND_SEG, 32'h10, 2'h0, 2'h0);
        ex(KIND_SEG, 32'h10, 2'h0, 2'h3);
        bus(1, REG_PAGE, 32'h6);
        ex(KIND_SEG, 32'h10, 2'h0, 2'h2);
        bus(1, REG_SEL, 32'h20001);
        ex(KIND_SEG, 32'h10, 2'h0, 2'h0);
        bus(0, REG_STATUS, 32'h0);
        chk({21'h0, rd[17:7]}, {21'h0, 4'hA, 1'h1, 2'h3, 2'h1, 2'h2});
        bus(1, REG_PAGE, 32'h4);
        ex(KIND_SEG, 32'h10, 2'h0, 2'h2);
        bus(1, REG_CTRL, 32'hB);
        ex(KIND_SEG, 32'h10, 2'h0, 2'h3);
    endtask
    // Reset for eight cycles, then run every scenario.
    initial
    begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'h0;
        t_limit;
        t_expand;
        t_long;
        t_table;
        t_page;
        close_out;
    end
endmodule
